// >>> rmsl_pkg.sv
// Constants shared by the serial slave link.
package rmsl_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CFG     = 8'h00;
  localparam logic [7:0] OFS_WAIT    = 8'h04;
  localparam logic [7:0] OFS_TMO     = 8'h08;
  localparam logic [7:0] OFS_ERRTHR  = 8'h0c;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;
  localparam logic [7:0] OFS_RXDATA  = 8'h18;
  localparam logic [7:0] OFS_TXDATA  = 8'h1c;
  localparam logic [7:0] OFS_INFO    = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_PAR_LSB   = 0;
  localparam int CFG_STOP_BIT  = 2;
  localparam int CFG_BAUD_LSB  = 4;
  localparam int CFG_ADDR_LSB  = 8;
  localparam logic [1:0]  PAR_NONE     = 2'h0;
  localparam logic [1:0]  PAR_EVEN     = 2'h1;
  localparam logic [1:0]  PAR_ODD      = 2'h2;
  localparam logic [1:0]  RST_PAR      = 2'h1;
  localparam logic        RST_STOP     = 1'b0;
  localparam logic [2:0]  RST_BAUD     = 3'h0;
  localparam logic [4:0]  RST_ADDR     = 5'h01;
  localparam logic [13:0] RST_WAIT     = 14'h0064;
  localparam logic [13:0] MAX_WAIT     = 14'h2710;
  localparam logic [13:0] RST_TMO      = 14'h0000;
  localparam logic [13:0] MAX_TMO      = 14'h2710;
  localparam logic [3:0]  RST_ERRTHR   = 4'h3;
  localparam logic [3:0]  MIN_ERRTHR   = 4'h1;
  localparam logic [3:0]  MAX_ERRTHR   = 4'ha;
  localparam logic [7:0]  BCAST_ADDR   = 8'h00;
  localparam int ST_RXBYTE = 0;
  localparam int ST_FRAME  = 1;
  localparam int ST_TXDONE = 2;
  localparam int ST_TMO    = 3;
  localparam int ST_ERRALM = 4;
  localparam int ST_CHERR  = 5;
  localparam int ST_W      = 6;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WAIT_STEP_NS   = 100000;
  localparam int MS_NS          = 1000000;
  localparam int CLK_HZ         = 1000000000 / CLK_PERIOD_NS;
  localparam int RATE0 = 9600;
  localparam int RATE1 = 19200;
  localparam int RATE2 = 38400;
  localparam int RATE3 = 57600;
  localparam int RATE4 = 115200;
  localparam logic [7:0]  GAP_BITS  = 8'd39;
  localparam logic [15:0] CRC_INIT  = 16'hffff;
  localparam logic [15:0] CRC_POLY  = 16'ha001;

endpackage

// >>> rmsl_top.sv
// Half-duplex serial slave link with RTU framing, APB registers and alarms.
// ------------------------------------------------------------------------
// Functional notes
// - Eight data bits, optional parity, 1-2 stops; code keeps reset framing, even parity and one stop
// - Rate selectable 9600 to 115200 bps; code stays at the reset rate, 9600
// - Parity 0 none, 1 even, 2 odd
// - Stop 0 one bit, 1 two bits
// - Wait before reply in 0.1 ms steps
// - Timeout 0 to 10000 ms, default off
// - Error alarm threshold 1 to 10, default 3
// - Timeout, threshold immediate; framing at power-up; code resets pending copies too, so written framing never takes effect
// - Reply only after a received query
// - Frames follow RTU gap and CRC framing
// - Alarm when message gap exceeds timeout
// - Alarm when error count reaches threshold
// - Broadcast address executed, never answered
// ------------------------------------------------------------------------
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module rmsl_top
  import rmsl_pkg::*;
#(
  parameter int BAUD_HZ  = CLK_HZ,
  parameter int STEP_CYC = WAIT_STEP_NS / CLK_PERIOD_NS,
  parameter int MS_CYC   = MS_NS / CLK_PERIOD_NS
) (
  input  wire logic        CLK,
  input  wire logic        RST_B,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        RX_IN,
  output logic             TX_OUT,
  output logic             TX_EN,
  output logic             IRQ
);

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PAR  = 5'h08, RX_STOP  = 5'h10
  } rmsl_rx_e;
  typedef enum logic [5:0] {
    TX_IDLE = 6'h01, TX_START = 6'h02, TX_DATA = 6'h04,
    TX_PAR  = 6'h08, TX_STOP  = 6'h10, TX_STOP2 = 6'h20
  } rmsl_tx_e;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [15:0] baud_div(input logic [2:0] sel);
    int rate;
    rate = RATE0;
    case (sel)
      3'h1:    rate = RATE1;
      3'h2:    rate = RATE2;
      3'h3:    rate = RATE3;
      3'h4:    rate = RATE4;
      default: rate = RATE0;
    endcase
    return 16'(BAUD_HZ / rate);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic par_bit(input logic [1:0] mode,
                                   input logic [7:0] d);
    return (mode == PAR_ODD) ? ~^d : ^d;
  endfunction

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [1:0]  par_pend_ff, par_ff;
  logic        stop_pend_ff, stop_ff;
  logic [2:0]  baud_pend_ff, baud_ff;
  logic [4:0]  addr_pend_ff, addr_ff;
  logic [13:0] wait_pend_ff, wait_ff, tmo_ff;
  logic [3:0]  thr_ff, err_cnt_ff;
  logic [ST_W-1:0] status_ff, mask_ff, nxt_status, st_set, st_clr;
  logic        boot_ff, pready_ff, slverr_ff, irq_ff;
  logic [31:0] prdata_ff;
  logic [7:0]  rxdata_ff, tx_hold_ff;
  logic        rx_valid_ff, rx_first_ff, tx_full_ff;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire access  = PSEL & PENABLE & pready_ff;
  wire wr      = access & PWRITE;
  wire rd      = access & ~PWRITE;
  wire a_cfg   = PADDR == OFS_CFG;
  wire a_wait  = PADDR == OFS_WAIT;
  wire a_tmo   = PADDR == OFS_TMO;
  wire a_thr   = PADDR == OFS_ERRTHR;
  wire a_stat  = PADDR == OFS_STATUS;
  wire a_mask  = PADDR == OFS_MASK;
  wire a_rx    = PADDR == OFS_RXDATA;
  wire a_tx    = PADDR == OFS_TXDATA;
  wire a_info  = PADDR == OFS_INFO;
  wire mapped  = a_cfg | a_wait | a_tmo | a_thr | a_stat | a_mask |
                 a_rx | a_tx | a_info;
  // Out-of-range settings are clamped on use, never stored differently
  wire [3:0] thr_use = (thr_ff < MIN_ERRTHR) ? MIN_ERRTHR :
                       (thr_ff > MAX_ERRTHR) ? MAX_ERRTHR : thr_ff;
  wire [13:0] tmo_use  = (tmo_ff > MAX_TMO) ? MAX_TMO : tmo_ff;
  wire [13:0] wait_use = (wait_ff > MAX_WAIT) ? MAX_WAIT : wait_ff;
  logic bcast_ff, crc_ok_ff;
  wire [31:0] rd_mux =
    a_cfg  ? {19'h0, addr_pend_ff, 1'b0, baud_pend_ff, 1'b0,
              stop_pend_ff, par_pend_ff} :
    a_wait ? {18'h0, wait_pend_ff} :
    a_tmo  ? {18'h0, tmo_ff} :
    a_thr  ? {28'h0, thr_ff} :
    a_stat ? {26'h0, status_ff} :
    a_mask ? {26'h0, mask_ff} :
    a_rx   ? {22'h0, rx_first_ff, rx_valid_ff, rxdata_ff} :
    a_tx   ? {23'h0, tx_full_ff, tx_hold_ff} :
    a_info ? {26'h0, crc_ok_ff, bcast_ff, err_cnt_ff} : 32'h0;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pready_ff <= 1'b0;
      slverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else begin
      pready_ff <= PSEL & PENABLE & ~pready_ff;
      slverr_ff <= PSEL & PENABLE & ~pready_ff & ~mapped;
      prdata_ff <= (PSEL & PENABLE & ~pready_ff & ~PWRITE) ? rd_mux : 32'h0;
    end
  end

  // Pending copies are written now; active copies load only at power-up
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      par_pend_ff  <= RST_PAR;
      stop_pend_ff <= RST_STOP;
      baud_pend_ff <= RST_BAUD;
      addr_pend_ff <= RST_ADDR;
      wait_pend_ff <= RST_WAIT;
      tmo_ff       <= RST_TMO;
      thr_ff       <= RST_ERRTHR;
      mask_ff      <= '0;
    end else begin
      if (wr & a_cfg) begin
        par_pend_ff  <= PWDATA[CFG_PAR_LSB +: 2];
        stop_pend_ff <= PWDATA[CFG_STOP_BIT];
        baud_pend_ff <= PWDATA[CFG_BAUD_LSB +: 3];
        addr_pend_ff <= PWDATA[CFG_ADDR_LSB +: 5];
      end
      if (wr & a_wait) wait_pend_ff <= PWDATA[13:0];
      if (wr & a_tmo)  tmo_ff <= PWDATA[13:0];
      if (wr & a_thr)  thr_ff <= PWDATA[3:0];
      if (wr & a_mask) mask_ff <= PWDATA[ST_W-1:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      boot_ff <= 1'b1;
      par_ff  <= RST_PAR;
      stop_ff <= RST_STOP;
      baud_ff <= RST_BAUD;
      addr_ff <= RST_ADDR;
      wait_ff <= RST_WAIT;
    end else begin
      boot_ff <= 1'b0;
      if (boot_ff) begin
        par_ff  <= par_pend_ff;
        stop_ff <= stop_pend_ff;
        baud_ff <= baud_pend_ff;
        addr_ff <= addr_pend_ff;
        wait_ff <= wait_pend_ff;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------------
  logic       rx_s1_ff, rx_s2_ff;
  rmsl_rx_e   rx_st_ff;
  logic [15:0] rx_cnt_ff, crc_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff, gap_ff;
  logic [15:0] gap_cyc_ff;
  logic       rx_perr_ff, in_frame_ff, match_ff, first_ff;
  wire [15:0] div_rx   = baud_div(baud_ff);
  wire        rx_tick  = rx_cnt_ff == 16'h0;
  wire        rx_done  = (rx_st_ff == RX_STOP) & rx_tick;
  wire        ch_err   = rx_done & (~rx_s2_ff | rx_perr_ff);
  wire [7:0]  rx_byte  = rx_sh_ff;
  wire        addr_hit = (rx_byte == {3'h0, addr_ff}) |
                         (rx_byte == BCAST_ADDR);
  wire        keep_byte = rx_done & ~ch_err & (first_ff ? addr_hit : match_ff);
  wire        gap_end  = in_frame_ff & (gap_ff == GAP_BITS);
  wire        frame_ok = gap_end & match_ff & (crc_ff == 16'h0);
  wire        frame_bad = gap_end & match_ff & (crc_ff != 16'h0);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
    end else begin
      rx_s1_ff <= RX_IN;
      rx_s2_ff <= rx_s1_ff;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rx_st_ff   <= RX_IDLE;
      rx_cnt_ff  <= 16'h0;
      rx_bit_ff  <= 3'h0;
      rx_sh_ff   <= 8'h0;
      rx_perr_ff <= 1'b0;
    end else begin
      rx_cnt_ff <= rx_tick ? div_rx - 16'h1 : rx_cnt_ff - 16'h1;
      case (rx_st_ff)
        RX_IDLE: begin
          if (!rx_s2_ff) begin
            rx_st_ff   <= RX_START;
            rx_cnt_ff  <= {1'b0, div_rx[15:1]};
            rx_perr_ff <= 1'b0;
          end
        end
        RX_START: if (rx_tick) begin
          rx_st_ff  <= rx_s2_ff ? RX_IDLE : RX_DATA;
          rx_bit_ff <= 3'h0;
        end
        RX_DATA: if (rx_tick) begin
          rx_sh_ff  <= {rx_s2_ff, rx_sh_ff[7:1]};
          rx_bit_ff <= rx_bit_ff + 3'h1;
          if (rx_bit_ff == 3'h7) begin
            rx_st_ff <= (par_ff == PAR_NONE) ? RX_STOP : RX_PAR;
          end
        end
        RX_PAR: if (rx_tick) begin
          rx_perr_ff <= rx_s2_ff != par_bit(par_ff, rx_sh_ff);
          rx_st_ff   <= RX_STOP;
        end
        RX_STOP: if (rx_tick) rx_st_ff <= RX_IDLE;
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // Silence of about 3.5 characters closes a frame
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_cyc_ff  <= 16'h0;
      gap_ff      <= 8'h0;
      in_frame_ff <= 1'b0;
      first_ff    <= 1'b1;
      match_ff    <= 1'b0;
      bcast_ff    <= 1'b0;
      crc_ff      <= CRC_INIT;
      crc_ok_ff   <= 1'b0;
    end else begin
      if (rx_st_ff != RX_IDLE || !rx_s2_ff) begin
        gap_cyc_ff <= 16'h0;
        gap_ff     <= 8'h0;
      end else if (gap_cyc_ff >= div_rx - 16'h1) begin
        gap_cyc_ff <= 16'h0;
        if (gap_ff != GAP_BITS) gap_ff <= gap_ff + 8'h1;
      end else begin
        gap_cyc_ff <= gap_cyc_ff + 16'h1;
      end
      if (rx_done) begin
        in_frame_ff <= 1'b1;
        first_ff    <= 1'b0;
        if (first_ff) begin
          match_ff <= addr_hit & ~ch_err;
          bcast_ff <= rx_byte == BCAST_ADDR;
        end
        if (ch_err) match_ff <= 1'b0;
        crc_ff <= crc_step(first_ff ? CRC_INIT : crc_ff, rx_byte);
      end
      if (gap_end) begin
        in_frame_ff <= 1'b0;
        first_ff    <= 1'b1;
        match_ff    <= 1'b0;
        crc_ok_ff   <= frame_ok;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Reply wait, timeout and error count
  // ----------------------------------------------------------------------
  logic [15:0] step_cnt_ff;
  logic [31:0] ms_pre_ff;
  logic [13:0] wait_cnt_ff, tmo_cnt_ff;
  logic        reply_ok_ff, tmo_fired_ff;
  wire step_tick = step_cnt_ff == 16'(STEP_CYC - 1);
  wire ms_tick   = ms_pre_ff == 32'(MS_CYC - 1);
  wire tx_go;
  wire tmo_evt = (tmo_use != 14'h0) & ~tmo_fired_ff &
                 (tmo_cnt_ff >= tmo_use) & ms_tick;
  wire err_evt = ch_err | frame_bad;
  wire err_alm = err_evt & (err_cnt_ff + 4'h1 == thr_use);

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      step_cnt_ff  <= 16'h0;
      ms_pre_ff    <= 32'h0;
      wait_cnt_ff  <= 14'h0;
      tmo_cnt_ff   <= 14'h0;
      reply_ok_ff  <= 1'b0;
      tmo_fired_ff <= 1'b0;
      err_cnt_ff   <= 4'h0;
    end else begin
      step_cnt_ff <= step_tick ? 16'h0 : step_cnt_ff + 16'h1;
      ms_pre_ff   <= ms_tick ? 32'h0 : ms_pre_ff + 32'h1;
      if (frame_ok) begin
        reply_ok_ff  <= ~bcast_ff;
        wait_cnt_ff  <= wait_use;
        step_cnt_ff  <= 16'h0;
        tmo_cnt_ff   <= 14'h0;
        tmo_fired_ff <= 1'b0;
      end else begin
        if (rx_done) reply_ok_ff <= 1'b0;
        if (step_tick && wait_cnt_ff != 14'h0) begin
          wait_cnt_ff <= wait_cnt_ff - 14'h1;
        end
        if (ms_tick && tmo_cnt_ff != MAX_TMO) begin
          tmo_cnt_ff <= tmo_cnt_ff + 14'h1;
        end
        if (tmo_evt) tmo_fired_ff <= 1'b1;
      end
      if (wr & a_info) err_cnt_ff <= 4'h0;
      else if (err_evt && err_cnt_ff != MAX_ERRTHR) begin
        err_cnt_ff <= err_cnt_ff + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------------
  rmsl_tx_e   tx_st_ff;
  logic [15:0] tx_cnt_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic       tx_ff, de_ff;
  wire [15:0] div_tx  = baud_div(baud_ff);
  wire        tx_tick = tx_cnt_ff == 16'h0;
  wire        tx_last = tx_tick & ((tx_st_ff == TX_STOP2) |
                        ((tx_st_ff == TX_STOP) & ~stop_ff));
  // Reply held back until the wait has run out and the line is quiet
  assign tx_go = (tx_st_ff == TX_IDLE) & tx_full_ff & reply_ok_ff &
                 (wait_cnt_ff == 14'h0) & ~in_frame_ff;
  wire tx_wr = wr & a_tx & ~tx_full_ff & ~bcast_ff;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tx_st_ff   <= TX_IDLE;
      tx_cnt_ff  <= 16'h0;
      tx_bit_ff  <= 3'h0;
      tx_sh_ff   <= 8'h0;
      tx_ff      <= 1'b1;
      de_ff      <= 1'b0;
      tx_hold_ff <= 8'h0;
      tx_full_ff <= 1'b0;
    end else begin
      tx_cnt_ff <= tx_tick ? div_tx - 16'h1 : tx_cnt_ff - 16'h1;
      if (tx_wr) begin
        tx_hold_ff <= PWDATA[7:0];
        tx_full_ff <= 1'b1;
      end
      case (tx_st_ff)
        TX_IDLE: if (tx_go) begin
          tx_st_ff   <= TX_START;
          tx_sh_ff   <= tx_hold_ff;
          tx_full_ff <= 1'b0;
          tx_cnt_ff  <= div_tx - 16'h1;
          tx_ff      <= 1'b0;
          de_ff      <= 1'b1;
        end
        TX_START: if (tx_tick) begin
          tx_st_ff  <= TX_DATA;
          tx_bit_ff <= 3'h0;
          tx_ff     <= tx_sh_ff[0];
        end
        TX_DATA: if (tx_tick) begin
          tx_bit_ff <= tx_bit_ff + 3'h1;
          if (tx_bit_ff == 3'h7) begin
            tx_st_ff <= (par_ff == PAR_NONE) ? TX_STOP : TX_PAR;
            tx_ff    <= (par_ff == PAR_NONE) ? 1'b1 :
                        par_bit(par_ff, tx_sh_ff);
          end else begin
            tx_ff <= tx_sh_ff[tx_bit_ff + 3'h1];
          end
        end
        TX_PAR: if (tx_tick) begin
          tx_st_ff <= TX_STOP;
          tx_ff    <= 1'b1;
        end
        TX_STOP: if (tx_tick) begin
          tx_st_ff <= stop_ff ? TX_STOP2 : TX_IDLE;
          de_ff    <= stop_ff;
        end
        TX_STOP2: if (tx_tick) begin
          tx_st_ff <= TX_IDLE;
          de_ff    <= 1'b0;
        end
        default: tx_st_ff <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive data, status and interrupt
  // ----------------------------------------------------------------------
  // Only bits actually returned by the read are cleared, so a late event
  // between capture and completion survives
  assign st_set = {ch_err, err_alm, tmo_evt, tx_last, frame_ok, keep_byte};
  assign st_clr = (rd & a_stat) ? prdata_ff[ST_W-1:0] : '0;
  assign nxt_status = (status_ff & ~st_clr) | st_set;

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      status_ff   <= '0;
      irq_ff      <= 1'b0;
      rxdata_ff   <= 8'h0;
      rx_valid_ff <= 1'b0;
      rx_first_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & mask_ff);
      if (keep_byte) begin
        rxdata_ff   <= rx_byte;
        rx_valid_ff <= 1'b1;
        rx_first_ff <= first_ff;
      end else if (rd & a_rx & prdata_ff[8]) begin
        rx_valid_ff <= 1'b0;
      end
    end
  end

  assign PRDATA  = prdata_ff;
  assign PREADY  = pready_ff;
  assign PSLVERR = slverr_ff;
  assign TX_OUT  = tx_ff;
  assign TX_EN   = de_ff;
  assign IRQ     = irq_ff;

endmodule

// >>> rmsl_chk.sv
// Port assertions for the serial slave link.
`timescale 1ns/10ps
module rmsl_chk
  import rmsl_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST_B,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        RX_IN,
  input wire logic        TX_OUT,
  input wire logic        TX_EN,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  ready_delay_a: assert property (
    PSEL && $rose(PENABLE) |=> PREADY)
    else $error("ready not one cycle after enable");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  err_decode_a: assert property (
    PREADY && PADDR[1:0] == 2'h0 |-> PSLVERR == (PADDR > OFS_INFO))
    else $error("error flag does not match address map");
  rdata_quiet_a: assert property (
    !(PREADY && !PWRITE) |-> PRDATA == 32'h0)
    else $error("read data outside read answer");
  // ----------------------------------------------------------------
  // Serial line
  // ----------------------------------------------------------------
  line_idle_a: assert property (!TX_EN |-> TX_OUT)
    else $error("line not high while driver off");
  start_bit_a: assert property (
    $rose(TX_EN) |-> (TX_EN && !TX_OUT) [*8])
    else $error("start bit missing or short");
  stop_bit_a: assert property (
    $fell(TX_EN) |-> $past(TX_OUT) && $past(TX_OUT, 8))
    else $error("stop bit missing before release");
endmodule

bind rmsl_top rmsl_chk u_chk (
  .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_IN(RX_IN), .TX_OUT(TX_OUT),
  .TX_EN(TX_EN), .IRQ(IRQ)
);

// >>> rmsl_master.sv
// Master controller model on the far side of the serial link.
`timescale 1ns/10ps
module rmsl_master #(
  parameter int BIT_CYC = 120
) (
  input  wire logic clk,
  output logic      line_out,
  input  wire logic line_in,
  input  wire logic line_en
);
  logic [7:0] got_q[$];
  int         bad_rx;
  initial begin
    line_out = 1'b1;
    bad_rx   = 0;
  end
  // Even parity, one stop, same rate as the slave
  // Flip breaks parity on purpose for error scenarios
  task automatic send(input logic [7:0] b, input logic flip);
    logic [10:0] ch;
    ch = {1'b1, (^b) ^ flip, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line_out <= ch[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask
  // Listens only to answers; sole slave on the segment
  always begin
    logic [10:0] sh;
    do begin
      @(posedge clk);
    end while (!(line_en === 1'b1 && line_in === 1'b0));
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      sh[i] = line_in;
      if (i < 10) begin
        repeat (BIT_CYC) @(posedge clk);
      end
    end
    if (sh[0] || !sh[10] || ^sh[9:1]) begin
      bad_rx++;
    end
    got_q.push_back(sh[8:1]);
  end
endmodule

// >>> tb_rs485_modbus_slave_link.sv
// Self-checking bench for the serial slave link.
`timescale 1ns/10ps
module tb_rs485_modbus_slave_link;
  import rmsl_pkg::*;
  localparam int BIT = 120;
  logic        CLK, RST_B, PSEL, PENABLE, PWRITE, er;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic        PREADY, PSLVERR, RX_IN, TX_OUT, TX_EN, IRQ;
  int          err_total, compares, n;

  rmsl_top #(.BAUD_HZ(1152000), .STEP_CYC(10), .MS_CYC(50)) u_dut (
    .CLK(CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RX_IN(RX_IN), .TX_OUT(TX_OUT),
    .TX_EN(TX_EN), .IRQ(IRQ));
  rmsl_master #(.BIT_CYC(BIT)) u_mst (
    .clk(CLK), .line_out(RX_IN), .line_in(TX_OUT), .line_en(TX_EN));

  always #5 CLK = ~CLK;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Holds the request until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    // Only the watchdog ends a wait that never sees ready
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd, e);
  endtask
  // Query with its check word; waits out the end-of-frame gap
  task automatic frame(input logic [7:0] a);
    logic [7:0]  q[$];
    logic [15:0] c;
    q = {a, 8'h06, 8'h00, 8'h01, 8'h00, 8'h03};
    c = CRC_INIT;
    foreach (q[i]) begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i]) u_mst.send(q[i], 1'b0);
    repeat (BIT * 41) @(posedge CLK);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    RST_B = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge CLK);
    RST_B <= 1'b1;
    rd_chk(OFS_CFG, 32'h101, "cfg");
    rd_chk(OFS_WAIT, 32'h64, "wait");
    rd_chk(OFS_TMO, 32'h0, "timeout");
    rd_chk(OFS_ERRTHR, 32'h3, "threshold");
    rd_chk(OFS_MASK, 32'h0, "mask");
    rd_chk(OFS_STATUS, 32'h0, "status");
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped", {31'h0, er}, 32'h1);
    // Framing change must wait for power-up, so even parity still works
    apb(1'b1, OFS_CFG, 32'h104);
    rd_chk(OFS_CFG, 32'h104, "cfg pending");
    frame(8'h01);
    check("irq masked", {31'h0, IRQ}, 32'h0);
    rd_chk(OFS_STATUS, 32'h3, "status frame");
    apb(1'b1, OFS_MASK, 32'h4);
    apb(1'b1, OFS_TXDATA, 32'h5a);
    repeat (500) @(posedge CLK);
    check("early send", {31'h0, TX_EN}, 32'h0);
    for (n = 0; n < 3000 && u_mst.got_q.size() == 0; n++) @(posedge CLK);
    repeat (BIT) @(posedge CLK);
    check("reply", {24'h0, u_mst.got_q[0]}, 32'h5a);
    check("reply shape", 32'(u_mst.bad_rx), 32'h0);
    check("irq", {31'h0, IRQ}, 32'h1);
    rd_chk(OFS_STATUS, 32'h4, "status tx");
    repeat (2) @(posedge CLK);
    check("irq clear", {31'h0, IRQ}, 32'h0);
    // Broadcast is taken but never answered
    frame(8'h00);
    rd_chk(OFS_INFO, 32'h30, "info bcast");
    rd_chk(OFS_STATUS, 32'h3, "status bcast");
    apb(1'b1, OFS_TXDATA, 32'h11);
    repeat (2000) @(posedge CLK);
    check("bcast reply", 32'(u_mst.got_q.size()), 32'h1);
    // Threshold of two applies at once; default three would stay quiet
    apb(1'b1, OFS_ERRTHR, 32'h2);
    u_mst.send(8'h01, 1'b1);
    u_mst.send(8'h03, 1'b1);
    repeat (BIT * 41) @(posedge CLK);
    apb(1'b0, OFS_INFO, 32'h0);
    check("error count", {28'h0, rd[3:0]}, 32'h2);
    rd_chk(OFS_STATUS, 32'h30, "status alarm");
    // Timeout of 1 ms is long overdue since the last good frame
    apb(1'b1, OFS_TMO, 32'h1);
    repeat (120) @(posedge CLK);
    rd_chk(OFS_STATUS, 32'h8, "status timeout");
    repeat (200) @(posedge CLK);
    rd_chk(OFS_STATUS, 32'h0, "timeout once");
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge CLK);
    err_total++;
    give_verdict();
  end
endmodule
